// *** hw/sonet_tx_overhead_insert.sv ***
// transmit overhead inserter: parity, line alarm, trace, k1/k2, s1, g1
//
// Added by the designer: the plain strobed port.
`include "sonet_tx_overhead_consts.svh"

module sonet_tx_overhead_insert import sonet_tx_overhead_pkg::*; #(
  parameter logic [6:0] LAST_COL = `COL_LAST,
  parameter logic [4:0] RDI_HOLD = `RDI_HOLD_FRAMES
) (
  input wire logic clk, // 40 MHz frame clock
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic rx_signal_lost, // receive loss of signal
  input wire logic rx_frame_lost, // receive loss of frame
  input wire logic rx_line_alarm, // receive line ais
  input wire logic rx_path_alarm, // receive path ais
  input wire logic rx_pointer_lost, // receive loss of pointer
  input wire logic rx_path_unequipped, // receive unequipped
  input wire logic rx_label_mismatch, // receive label mismatch
  input wire logic [7:0] rx_line_error_count, // b2 errors for m1
  input wire logic [3:0] rx_path_error_count, // b3 errors, 0..8
  input wire logic in_valid, // upstream byte valid
  input wire logic [7:0] in_byte, // upstream byte
  input wire logic [3:0] in_row, // row of upstream byte
  input wire logic [6:0] in_col, // column of upstream byte
  output logic out_valid, // line byte valid
  output logic [7:0] out_byte, // line byte
  output logic [3:0] out_row, // row of line byte
  output logic [6:0] out_col // column of line byte
);

  // ----------------------------------------------------------------------
  // host registers
  // ----------------------------------------------------------------------
  logic [7:0] parity_r, alarm_r, k2_r, k1_r, s1_r, pathctl_r, perr_r;
  logic los_mask_r, trace_en_r;
  logic [7:0] rd_r;
  logic rd_sel_r;
  logic [7:0] trace_off;
  logic trace_hit;
  logic [7:0] ram_bus_q, ram_tx_q;
  logic [3:0] trace_idx_r;
  line_rdi_state_t rdi_state_r;
  logic [4:0] rdi_cnt_r;

  assign trace_off = reg_addr - `ADDR_TRACE_FIRST;
  assign trace_hit = reg_addr >= `ADDR_TRACE_FIRST && reg_addr <= `ADDR_TRACE_LAST;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      parity_r <= `REG_RESET;
      alarm_r <= `REG_RESET;
      k2_r <= `REG_RESET;
      k1_r <= `REG_RESET;
      s1_r <= `REG_RESET;
      pathctl_r <= `REG_RESET;
      perr_r <= `REG_RESET;
      los_mask_r <= 1'b0;
      trace_en_r <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_PARITY_SENSE: parity_r <= reg_wdata & `MASK_PARITY;
        `ADDR_ALARM_CTRL: alarm_r <= reg_wdata & `MASK_ALARM;
        `ADDR_LOS_MASK: los_mask_r <= reg_wdata[`BIT_LOS_MASK];
        `ADDR_TRACE_CTRL: trace_en_r <= reg_wdata[`BIT_TRACE_EN];
        `ADDR_PROT_TWO: k2_r <= reg_wdata;
        `ADDR_PROT_ONE: k1_r <= reg_wdata;
        `ADDR_SYNC_STATUS: s1_r <= reg_wdata;
        `ADDR_PATH_CTRL: pathctl_r <= reg_wdata & `MASK_PATH_CTRL;
        `ADDR_PATH_ERR_GEN: perr_r <= reg_wdata & `MASK_PATH_ERR;
        default: begin
        end
      endcase
    end
  end

  // trace bytes read back through the memory's own output register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_r <= `REG_RESET;
      rd_sel_r <= 1'b0;
    end else begin
      rd_sel_r <= reg_rd && trace_hit;
      rd_r <= `REG_RESET;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_PARITY_SENSE: rd_r <= parity_r;
          `ADDR_ALARM_CTRL: rd_r <= alarm_r;
          `ADDR_LOS_MASK: rd_r <= {7'h00, los_mask_r};
          `ADDR_TRACE_CTRL: rd_r <= {7'h00, trace_en_r};
          `ADDR_PROT_TWO: rd_r <= k2_r;
          `ADDR_PROT_ONE: rd_r <= k1_r;
          `ADDR_SYNC_STATUS: rd_r <= s1_r;
          `ADDR_PATH_CTRL: rd_r <= pathctl_r;
          `ADDR_STATUS: rd_r <= {3'h0, rdi_state_r == LRDI_HOLD, trace_idx_r};
          `ADDR_PATH_ERR_GEN: rd_r <= perr_r;
          default: rd_r <= `REG_RESET;
        endcase
      end
    end
  end

  assign reg_rdata = rd_sel_r ? ram_bus_q : rd_r;

  trace_ram #(.DEPTH(16), .AW(4), .W(8)) u_trace (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(reg_wr && trace_hit),
    .wr_addr(trace_off[3:0]),
    .wr_data(reg_wdata),
    .a_addr(trace_off[3:0]),
    .a_q(ram_bus_q),
    .b_addr(trace_idx_r),
    .b_q(ram_tx_q)
  );

  // ----------------------------------------------------------------------
  // frame boundary sampling
  // ----------------------------------------------------------------------
  logic frame_start, soh_zone;
  logic [7:0] sh_k1_r, sh_k2_r, sh_s1_r;
  logic [2:0] sh_pathctl_r, sh_g1man_r;
  logic sh_ais_r;

  assign frame_start = in_valid && in_row == `ROW_FRAME && in_col == `COL_A1;
  assign soh_zone = in_row <= `ROW_SOH_LAST && in_col <= `COL_OH_LAST;

  // a host write mid-frame cannot split one frame's k bytes or g1
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_k1_r <= `REG_RESET;
      sh_k2_r <= `REG_RESET;
      sh_s1_r <= `REG_RESET;
      sh_pathctl_r <= 3'h0;
      sh_g1man_r <= 3'h0;
      sh_ais_r <= 1'b0;
    end else if (frame_start) begin
      sh_k1_r <= k1_r;
      sh_k2_r <= k2_r;
      sh_s1_r <= s1_r;
      sh_pathctl_r <= pathctl_r[2:0];
      sh_g1man_r <= perr_r[`MG1_MSB:`MG1_LSB];
      sh_ais_r <= alarm_r[`BIT_FORCE_AIS];
    end
  end

  // ----------------------------------------------------------------------
  // section trace pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trace_idx_r <= `TRACE_TOP;
    end else if (!trace_en_r) begin
      trace_idx_r <= `TRACE_TOP;
    end else if (in_valid && in_row == `ROW_FRAME && in_col == `COL_J0) begin
      trace_idx_r <= trace_idx_r - 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // automatic line rdi with minimum hold
  // ----------------------------------------------------------------------
  logic line_defect;

  assign line_defect = !alarm_r[`BIT_LRDI_OFF] &&
    ((rx_signal_lost && !los_mask_r) || rx_frame_lost || rx_line_alarm);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdi_state_r <= LRDI_IDLE;
      rdi_cnt_r <= 5'h00;
    end else if (alarm_r[`BIT_LRDI_OFF]) begin
      rdi_state_r <= LRDI_IDLE;
      rdi_cnt_r <= 5'h00;
    end else if (frame_start) begin
      case (rdi_state_r)
        LRDI_IDLE: begin
          if (line_defect) begin
            rdi_state_r <= LRDI_HOLD;
            rdi_cnt_r <= RDI_HOLD;
          end
        end
        LRDI_HOLD: begin
          if (line_defect) begin
            rdi_cnt_r <= RDI_HOLD;
          end else if (rdi_cnt_r == 5'h01) begin
            rdi_state_r <= LRDI_IDLE;
            rdi_cnt_r <= 5'h00;
          end else begin
            rdi_cnt_r <= rdi_cnt_r - 5'h01;
          end
        end
        default: begin
          rdi_state_r <= LRDI_IDLE;
          rdi_cnt_r <= 5'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // parity accumulators: 0 section, 1 line, 2 path
  // ----------------------------------------------------------------------
  logic [7:0] out_nxt;
  logic [2:0] bip_take;
  logic [7:0] acc_r [3];
  logic [7:0] bip_r [3];

  assign bip_take = {in_col >= `COL_POH, !soh_zone, 1'b1};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : bip
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          acc_r[g] <= `REG_RESET;
          bip_r[g] <= `REG_RESET;
        end else if (frame_start) begin
          bip_r[g] <= acc_r[g];
          acc_r[g] <= bip_take[g] ? out_nxt : `REG_RESET;
        end else if (in_valid && bip_take[g]) begin
          acc_r[g] <= acc_r[g] ^ out_nxt;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // byte selection
  // ----------------------------------------------------------------------
  path_rdi_mode_t prdi_mode;
  logic [2:0] g1_rdi, k2_low;
  logic [3:0] g1_rei;
  logic path_server;

  assign path_server = rx_path_alarm || rx_pointer_lost;

  always_comb begin
    prdi_mode = PRDI_MANUAL;
    if (sh_pathctl_r[`BIT_PATH_DEFECT_AUTOMATIC]) begin
      prdi_mode = sh_pathctl_r[`BIT_PATH_DEFECT_ENHANCED] ? PRDI_ENHANCED : PRDI_PLAIN;
    end
    case (prdi_mode)
      PRDI_MANUAL: g1_rdi = sh_g1man_r;
      PRDI_PLAIN: g1_rdi = path_server ? `G1_PLAIN_DEF : `G1_NONE;
      PRDI_ENHANCED: begin
        if (path_server) begin
          g1_rdi = `G1_ENH_SERVER;
        end else if (rx_path_unequipped) begin
          g1_rdi = `G1_ENH_UNEQ;
        end else if (rx_label_mismatch) begin
          g1_rdi = `G1_ENH_PLM;
        end else begin
          g1_rdi = `G1_ENH_CLEAR;
        end
      end
      default: g1_rdi = `G1_NONE;
    endcase
  end

  assign g1_rei = sh_pathctl_r[`BIT_PREI_OFF] ? 4'h0 : rx_path_error_count;

  assign k2_low = sh_ais_r ? `K2_AIS :
    (rdi_state_r == LRDI_HOLD) ? `K2_RDI : sh_k2_r[2:0];

  always_comb begin
    out_nxt = in_byte;
    if (sh_ais_r && !soh_zone) begin
      out_nxt = `BYTE_ONES;
    end else if (in_row == `ROW_FRAME && in_col == `COL_A1) begin
      out_nxt = `BYTE_A1;
    end else if (in_row == `ROW_FRAME && in_col == `COL_A2) begin
      out_nxt = `BYTE_A2;
    end else if (in_row == `ROW_FRAME && in_col == `COL_J0) begin
      out_nxt = trace_en_r ? ram_tx_q : `J0_IDLE;
    end else if (in_row == `ROW_B1 && in_col == `COL_B1) begin
      out_nxt = bip_r[0] ^ {8{parity_r[`BIT_SECTION_ODD]}};
    end else if (in_row == `ROW_K && in_col == `COL_B2) begin
      out_nxt = bip_r[1] ^ {8{parity_r[`BIT_LINE_ODD]}};
    end else if (in_row == `ROW_K && in_col == `COL_K1) begin
      out_nxt = sh_k1_r;
    end else if (in_row == `ROW_K && in_col == `COL_K2) begin
      out_nxt = {sh_k2_r[7:3], k2_low};
    end else if (in_row == `ROW_S1 && in_col == `COL_S1) begin
      out_nxt = sh_s1_r;
    end else if (in_row == `ROW_S1 && in_col == `COL_M1) begin
      out_nxt = alarm_r[`BIT_LREI_OFF] ? `REG_RESET : rx_line_error_count;
    end else if (in_row == `ROW_B1 && in_col == `COL_POH) begin
      out_nxt = bip_r[2] ^ {8{parity_r[`BIT_PATH_ODD]}};
    end else if (in_row == `ROW_G1 && in_col == `COL_POH) begin
      out_nxt = {g1_rdi, 1'b0, g1_rei};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_byte <= `REG_RESET;
      out_row <= 4'h0;
      out_col <= 7'h00;
    end else begin
      out_valid <= in_valid;
      out_byte <= in_valid ? out_nxt : `REG_RESET;
      out_row <= in_row;
      out_col <= in_col;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic at_k2, at_g1, at_m1;
  assign at_k2 = out_valid && out_row == `ROW_K && out_col == `COL_K2;
  assign at_g1 = out_valid && out_row == `ROW_G1 && out_col == `COL_POH;
  assign at_m1 = out_valid && out_row == `ROW_S1 && out_col == `COL_M1;

  section_parity_a: assert property (
    out_valid && out_row == `ROW_B1 && out_col == `COL_B1 |->
    out_byte == ($past(bip_r[0]) ^ {8{$past(parity_r[`BIT_SECTION_ODD])}}))
    else $error("b1 parity sense wrong");
  path_parity_a: assert property (
    out_valid && out_row == `ROW_B1 && out_col == `COL_POH && !$past(sh_ais_r) |->
    out_byte == ($past(bip_r[2]) ^ {8{$past(parity_r[`BIT_PATH_ODD])}}))
    else $error("b3 parity sense wrong");
  line_alarm_ones_a: assert property (
    out_valid && $past(sh_ais_r) &&
    !(out_row <= `ROW_SOH_LAST && out_col <= `COL_OH_LAST) |-> out_byte == `BYTE_ONES)
    else $error("line alarm byte not all ones");
  rdi_inhibit_a: assert property (
    alarm_r[`BIT_LRDI_OFF] |=> rdi_state_r == LRDI_IDLE)
    else $error("line rdi active while inhibited");
  rei_inhibit_a: assert property (
    at_m1 && !$past(sh_ais_r) && $past(alarm_r[`BIT_LREI_OFF]) |-> out_byte == `REG_RESET)
    else $error("line rei sent while inhibited");
  trace_descend_a: assert property (
    $past(trace_en_r) && trace_en_r && trace_idx_r != $past(trace_idx_r) |->
    trace_idx_r == $past(trace_idx_r) - 4'h1)
    else $error("trace index not descending");
  k_bytes_a: assert property (
    out_valid && out_row == `ROW_K && out_col == `COL_K1 && !$past(sh_ais_r) |->
    out_byte == $past(sh_k1_r))
    else $error("k1 byte not programmed value");
  k2_upper_a: assert property (
    at_k2 && !$past(sh_ais_r) |-> out_byte[7:3] == $past(sh_k2_r[7:3]))
    else $error("k2 upper bits wrong");
  k2_priority_a: assert property (
    at_k2 && !$past(sh_ais_r) && $past(rdi_state_r) == LRDI_IDLE |->
    out_byte[2:0] == $past(sh_k2_r[2:0]))
    else $error("k2 low bits not programmed value");
  rdi_hold_a: assert property (
    frame_start && line_defect && !alarm_r[`BIT_LRDI_OFF] |=>
    rdi_state_r == LRDI_HOLD && rdi_cnt_r == RDI_HOLD)
    else $error("line rdi hold not loaded");
  sync_status_a: assert property (
    out_valid && out_row == `ROW_S1 && out_col == `COL_S1 && !$past(sh_ais_r) |->
    out_byte == $past(sh_s1_r))
    else $error("s1 byte wrong");
  g1_rei_a: assert property (
    at_g1 && !$past(sh_ais_r) |-> out_byte[3:0] ==
    ($past(sh_pathctl_r[`BIT_PREI_OFF]) ? 4'h0 : $past(rx_path_error_count)))
    else $error("g1 rei nibble wrong");
  g1_enhanced_a: assert property (
    at_g1 && !$past(sh_ais_r) && $past(prdi_mode) == PRDI_ENHANCED &&
    $past(path_server) |-> out_byte[7:5] == `G1_ENH_SERVER)
    else $error("enhanced rdi code wrong");
  frame_sample_a: assert property (
    !frame_start |=> $stable(sh_k1_r) && $stable(sh_k2_r) && $stable(sh_pathctl_r))
    else $error("settings changed inside a frame");

endmodule

// *** hw/sonet_tx_overhead_consts.svh ***
// named constants for the transmit overhead inserter
`ifndef SONET_TX_OVERHEAD_CONSTS_SVH
`define SONET_TX_OVERHEAD_CONSTS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define ADDR_PARITY_SENSE 8'h9c
`define ADDR_ALARM_CTRL 8'h9d
`define ADDR_LOS_MASK 8'h9e
`define ADDR_TRACE_FIRST 8'h9f
`define ADDR_TRACE_LAST 8'hae
`define ADDR_TRACE_CTRL 8'haf
`define ADDR_PROT_TWO 8'hb0
`define ADDR_PROT_ONE 8'hb1
`define ADDR_SYNC_STATUS 8'hb3
`define ADDR_PATH_CTRL 8'hb4
`define ADDR_STATUS 8'hb5
`define ADDR_PATH_ERR_GEN 8'hf7

// ----------------------------------------------------------------------
// field positions, masks, reset values
// ----------------------------------------------------------------------
`define REG_RESET 8'h00
`define BIT_SECTION_ODD 2
`define BIT_LINE_ODD 1
`define BIT_PATH_ODD 0
`define BIT_FORCE_AIS 7
`define BIT_LRDI_OFF 1
`define BIT_LREI_OFF 0
`define BIT_PREI_OFF 2
`define BIT_PATH_DEFECT_ENHANCED 1
`define BIT_PATH_DEFECT_AUTOMATIC 0
`define BIT_TRACE_EN 0
`define BIT_LOS_MASK 0
`define MASK_PARITY 8'h07
`define MASK_ALARM 8'h83
`define MASK_PATH_CTRL 8'h07
`define MASK_PATH_ERR 8'h70
`define MASK_BIT0 8'h01
`define MG1_LSB 4
`define MG1_MSB 6

// ----------------------------------------------------------------------
// frame positions (sts-1 grid, spe fixed at column 3)
// ----------------------------------------------------------------------
`define COL_LAST 7'h59
`define ROW_FRAME 4'h0
`define ROW_B1 4'h1
`define ROW_SOH_LAST 4'h2
`define ROW_G1 4'h3
`define ROW_K 4'h4
`define ROW_S1 4'h8
`define COL_A1 7'h00
`define COL_A2 7'h01
`define COL_J0 7'h02
`define COL_B1 7'h00
`define COL_B2 7'h00
`define COL_K1 7'h01
`define COL_K2 7'h02
`define COL_S1 7'h00
`define COL_M1 7'h01
`define COL_OH_LAST 7'h02
`define COL_POH 7'h03

// ----------------------------------------------------------------------
// byte values and codes
// ----------------------------------------------------------------------
`define BYTE_A1 8'hf6
`define BYTE_A2 8'h28
`define BYTE_ONES 8'hff
`define J0_IDLE 8'h01
`define TRACE_TOP 4'hf
`define K2_AIS 3'h7
`define K2_RDI 3'h6
`define G1_PLAIN_DEF 3'h4
`define G1_NONE 3'h0
`define G1_ENH_SERVER 3'h5
`define G1_ENH_UNEQ 3'h6
`define G1_ENH_PLM 3'h2
`define G1_ENH_CLEAR 3'h1
`define RDI_HOLD_FRAMES 5'h14

`endif

// *** hw/sonet_tx_overhead_pkg.sv ***
// types shared by the transmit overhead inserter
package sonet_tx_overhead_pkg;

  typedef enum logic [1:0] {
    PRDI_MANUAL = 2'b00,
    PRDI_PLAIN = 2'b01,
    PRDI_ENHANCED = 2'b10
  } path_rdi_mode_t;

  typedef enum logic {
    LRDI_IDLE = 1'b0,
    LRDI_HOLD = 1'b1
  } line_rdi_state_t;

endpackage

// *** hw/trace_ram.sv ***
// small trace memory: one write port, two registered read ports
module trace_ram #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int W = 8
) (
  input wire logic clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write entry
  input wire logic [W-1:0] wr_data, // write data
  input wire logic [AW-1:0] a_addr, // read port a entry
  output logic [W-1:0] a_q, // port a data, registered
  input wire logic [AW-1:0] b_addr, // read port b entry
  output logic [W-1:0] b_q // port b data, registered
);

  logic [W-1:0] mem [DEPTH];

  // entries reset to zero, so the array is flops rather than a macro
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : entry
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem[g] <= '0;
        end else if (wr_en && wr_addr == AW'(g)) begin
          mem[g] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_q <= mem[a_addr];
      b_q <= mem[b_addr];
    end
  end

endmodule

// *** sim/sonet_line_rx_model.sv ***
// line-side receiver model: captures overhead bytes and frame parity sums
module sonet_line_rx_model (
  input wire logic clk, // line clock
  input wire logic arst_n, // async reset, active low
  input wire logic line_valid, // byte valid
  input wire logic [7:0] line_byte, // received byte
  input wire logic [3:0] line_row, // row of byte
  input wire logic [6:0] line_col, // column of byte
  output logic frame_done, // pulse after last byte of a frame
  output logic [71:0] oh, // j0 k1 k2 s1 g1 m1 b1 b2 b3
  output logic [23:0] bip_prev, // b1 b2 b3 sums of the frame before last
  output logic ais_clean // last frame all ones outside soh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] acc, acc_nxt, last;
  logic soh, bad, bad_nxt;
  assign soh = line_row < 4'd3 && line_col < 7'd3;
  assign acc_nxt = acc ^ {line_byte, soh ? 8'h00 : line_byte, line_col > 7'd2 ? line_byte : 8'h00};
  assign bad_nxt = bad | (!soh && line_byte != 8'hff);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_done <= 1'b0;
      oh <= '0;
      bip_prev <= '0;
      ais_clean <= 1'b0;
      acc <= '0;
      last <= '0;
      bad <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (line_valid) begin
        acc <= acc_nxt;
        bad <= bad_nxt;
        case ({line_row, line_col})
          {4'd0, 7'd2}: oh[71:64] <= line_byte;
          {4'd4, 7'd1}: oh[63:56] <= line_byte;
          {4'd4, 7'd2}: oh[55:48] <= line_byte;
          {4'd8, 7'd0}: oh[47:40] <= line_byte;
          {4'd3, 7'd3}: oh[39:32] <= line_byte;
          {4'd8, 7'd1}: oh[31:24] <= line_byte;
          {4'd1, 7'd0}: oh[23:16] <= line_byte;
          {4'd4, 7'd0}: oh[15:8] <= line_byte;
          {4'd1, 7'd3}: oh[7:0] <= line_byte;
          default: ;
        endcase
        // -----------------------------------------------------------
        // frame close: parity sent in a frame covers the one before it
        // -----------------------------------------------------------
        if (line_row == 4'd8 && line_col == 7'd89) begin
          frame_done <= 1'b1;
          acc <= '0;
          last <= acc_nxt;
          bip_prev <= last;
          ais_clean <= !bad_nxt;
          bad <= 1'b0;
        end
      end
    end
  end
endmodule

// *** sim/sonet_tx_overhead_insert_test.sv ***
// self-checking bench for the transmit overhead inserter
module sonet_tx_overhead_insert_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
  typedef struct {
    logic [7:0] j0, k1, k2, s1, g1, m1;
    logic [2:0] odd;
    logic ais;
  } frame_exp_t;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, in_byte = 8'h00, lcnt = 8'h00;
  logic [3:0] in_row = 4'h0, pd = 4'h0, pcnt = 4'h0, ti = 4'hf;
  logic [6:0] in_col = 7'h00;
  logic [2:0] ld = 3'h0;
  logic [7:0] reg_rdata, out_byte, x8, k1, k2, s1, lc;
  logic [3:0] out_row, pdv, pc;
  logic [6:0] out_col;
  logic [2:0] odd, ctl, man, ldv;
  logic out_valid, done, clean, ais, inh, lrei, te, msk;
  logic [71:0] oh;
  logic [23:0] bip;
  logic [31:0] st = 32'h424b;
  logic [7:0] ent[16];
  logic [7:0] ra[10] = '{8'h9c, 8'h9d, 8'h9f, 8'hae, 8'hb0, 8'hb1, 8'hb3, 8'hb4, 8'hf7, 8'hb2};
  logic [7:0] rm[10] = '{8'h07, 8'h83, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h70, 8'h00};
  int miscompares = 0, tests_run = 0, hold = 0;
  frame_exp_t fq[$];
  frame_exp_t e, m;
  logic [7:0] rq[$];

  sonet_tx_overhead_insert i_sonet_tx_overhead_insert (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_signal_lost(ld[2]), .rx_frame_lost(ld[1]),
    .rx_line_alarm(ld[0]), .rx_path_alarm(pd[3]), .rx_pointer_lost(pd[2]),
    .rx_path_unequipped(pd[1]), .rx_label_mismatch(pd[0]), .rx_line_error_count(lcnt),
    .rx_path_error_count(pcnt), .in_valid(in_valid), .in_byte(in_byte), .in_row(in_row),
    .in_col(in_col), .out_valid(out_valid), .out_byte(out_byte), .out_row(out_row),
    .out_col(out_col));
  sonet_line_rx_model i_sonet_line_rx_model (.clk(clk), .arst_n(arst_n),
    .line_valid(out_valid), .line_byte(out_byte), .line_row(out_row), .line_col(out_col),
    .frame_done(done), .oh(oh), .bip_prev(bip), .ais_clean(clean));

  initial begin
    forever #12.5 clk = ~clk;
  end

  function logic [7:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st[7:0];
  endfunction

  function logic [7:0] g1_exp(input logic [2:0] c, input logic [2:0] mv, input logic [3:0] d,
                              input logic [3:0] n);
    logic [2:0] v;
    if (!c[0]) v = mv;
    else if (!c[1]) v = (d[3] | d[2]) ? 3'b100 : 3'b000;
    else if (d[3] | d[2]) v = 3'b101;
    else if (d[1]) v = 3'b110;
    else if (d[0]) v = 3'b010;
    else v = 3'b001;
    return {v, 1'b0, c[2] ? 4'h0 : n};
  endfunction

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(x);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // mid-frame k1 rewrite must not reach the frame in flight
  task run_frame(input logic [7:0] kv);
    for (int r = 0; r < 9; r++) begin
      for (int c = 0; c < 90; c++) begin
        @(posedge clk);
        in_valid <= 1'b1;
        in_row <= 4'(r);
        in_col <= 7'(c);
        in_byte <= rnd();
        reg_wr <= (r == 2 && c == 50);
        reg_addr <= 8'hb1;
        reg_wdata <= ~kv;
      end
    end
    @(posedge clk);
    in_valid <= 1'b0;
  endtask

  task give_verdict();
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // monitors
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_d) begin
      x8 = rq.pop_front();
      `CHK("rdata", x8, reg_rdata);
    end
    rd_d <= reg_rd;
  end

  always @(posedge clk) begin
    if (done) begin
      m = fq.pop_front();
      `CHK("j0", m.j0, oh[71:64]);
      `CHK("b1", bip[23:16] ^ {8{m.odd[2]}}, oh[23:16]);
      if (m.ais) begin
        `CHK("ais", 1'b1, clean);
      end else begin
        `CHK("b2", bip[15:8] ^ {8{m.odd[1]}}, oh[15:8]);
        `CHK("b3", bip[7:0] ^ {8{m.odd[0]}}, oh[7:0]);
        `CHK("k1", m.k1, oh[63:56]);
        `CHK("k2", m.k2, oh[55:48]);
        `CHK("s1", m.s1, oh[47:40]);
        `CHK("g1", m.g1, oh[39:32]);
        `CHK("m1", m.m1, oh[31:24]);
      end
    end
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], 8'h00);
      wr(ra[i], 8'hff);
      rd(ra[i], rm[i]);
    end
    wr(8'hb5, 8'h00);
    rd(8'hb5, 8'h0f);
    for (int i = 0; i < 16; i++) begin
      ent[i] = rnd();
      wr(8'h9f + 8'(i), ent[i]);
    end
    for (int f = 0; f < 40; f++) begin
      k1 = rnd();
      k2 = rnd();
      s1 = rnd();
      lc = rnd();
      odd = (f == 0) ? 3'h0 : 3'(rnd());
      ctl = 3'(rnd());
      man = 3'(rnd());
      pdv = 4'(rnd());
      pc = 4'(rnd() % 9);
      lrei = rnd() > 8'd200;
      ais = f == 28 || f == 36;
      inh = f == 30 || f == 31;
      te = f >= 10 && f < 28;
      // masked loss of signal must not start line rdi
      msk = f == 27;
      ldv = {f == 1 || f == 27, f == 6, f == 30 || f == 33};
      wr(8'h9e, {7'h0, msk});
      wr(8'h9c, {5'h0, odd});
      wr(8'h9d, {ais, 5'h0, inh, lrei});
      wr(8'hb0, k2);
      wr(8'hb1, k1);
      wr(8'hb3, s1);
      wr(8'hb4, {5'h0, ctl});
      wr(8'hf7, {1'b0, man, 4'h0});
      wr(8'haf, {7'h0, te});
      @(posedge clk);
      ld <= ldv;
      pd <= pdv;
      pcnt <= pc;
      lcnt <= lc;
      if (inh) hold = 0;
      else if ((ldv[2] && !msk) || |ldv[1:0]) hold = 20;
      e.k2 = {k2[7:3], ais ? 3'h7 : (hold > 0) ? 3'h6 : k2[2:0]};
      if (hold > 0) hold--;
      e.j0 = te ? ent[ti] : 8'h01;
      ti = te ? ti - 4'h1 : 4'hf;
      e.k1 = k1;
      e.s1 = s1;
      e.m1 = lrei ? 8'h00 : lc;
      e.odd = odd;
      e.ais = ais;
      e.g1 = g1_exp(ctl, man, pdv, pc);
      fq.push_back(e);
      run_frame(k1);
    end
    for (int i = 0; i < 2000 && fq.size() > 0; i++) @(posedge clk);
    if (fq.size() > 0) miscompares++;
    give_verdict();
  end

  // hang guard: the full run needs well under this many cycles
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
